/* core/wcf_top.sv */
// Watchdog, two-speed start-up and fail-safe clock monitor with AXI4-Lite.
//
// Notes on behaviour
// - Watchdog ticks from internal RC, enabling it.
// - Base period 4 ms, 16-bit postscaler.
// - Selectable timeout, 4 ms to 131.072 s.
// - Sleep, clear, freq change, failure clear watchdog.
// - Watchdog timeout resets the device.
// - Software enable works only if config off.
// - Software enable at bit 0, rest zero.
// - Two-speed start-up needs its config bit.
// - Two-speed runs internal clock after reset/wake.
// - Start-up timer expiry switches to primary.
// - Two-speed uses selected internal frequency.
// - Other power modes ignore two-speed setting.
// - Clock select and sleep honoured during two-speed.
// - Primary-active status bit 3 of oscillator control.
// - Fail monitor keeps RC oscillator running.
// - Sample clock is RC divided by 64.
// - Clock-seen set device fall, cleared sample rise.
// - Sample fall with latch set means failure.
// - Failure sets oscillator-fail flag bit 7.
// - Failure selects internal clock, oscillator control unchanged.
// - Monitor checks primary and secondary sources only.
// - Watchdog disable leaves RC on with monitor.
// - Fail-safe ends on reset or power mode.
`timescale 1ns/10ps
module wcf_top
    import wcf_pkg::*;
(
    input  wire logic                      mclk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      rc_clk_in,
    input  wire logic                      dev_clk_in,
    input  wire logic                      sleep_exec_in,
    input  wire logic                      clear_watchdog_in,
    input  wire logic                      wake_in,
    input  wire logic                      startup_done_in,
    input  wire logic [wcf_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                      s_axi_awvalid_in,
    output logic                           s_axi_awready_out,
    input  wire logic [wcf_pkg::DATA_W-1:0] s_axi_wdata_in,
    input  wire logic [3:0]                s_axi_wstrb_in,
    input  wire logic                      s_axi_wvalid_in,
    output logic                           s_axi_wready_out,
    output logic [1:0]                     s_axi_bresp_out,
    output logic                           s_axi_bvalid_out,
    input  wire logic                      s_axi_bready_in,
    input  wire logic [wcf_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                      s_axi_arvalid_in,
    output logic                           s_axi_arready_out,
    output logic [wcf_pkg::DATA_W-1:0]     s_axi_rdata_out,
    output logic [1:0]                     s_axi_rresp_out,
    output logic                           s_axi_rvalid_out,
    input  wire logic                      s_axi_rready_in,
    output logic                           wdt_reset_out,
    output logic                           rc_osc_en_out,
    output logic [1:0]                     clk_src_out,
    output logic [2:0]                     int_freq_sel_out,
    output logic                           fail_safe_out
);
    import wcf_pkg::*;

    // =========================================================================
    // Reset release and pin synchronisers
    // =========================================================================
    logic rst_n;
    logic rc_s;
    logic dev_s;

    wcf_sync #(.RST_VAL(1'b0)) u_rst_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n_in),
        .d_in     (1'b1),
        .q_out    (rst_n)
    );

    wcf_sync #(.RST_VAL(1'b0)) u_rc_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n),
        .d_in     (rc_clk_in),
        .q_out    (rc_s)
    );

    wcf_sync #(.RST_VAL(1'b0)) u_dev_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n),
        .d_in     (dev_clk_in),
        .q_out    (dev_s)
    );

    // =========================================================================
    // State
    // =========================================================================
    wcf_regs_t   r;
    wcf_regs_t   n;
    logic        rc_rise;
    logic        dev_fall;
    logic        samp_rise;
    logic        samp_fall;
    logic        mon_on;
    logic        fail_evt;
    logic        wdt_en;
    logic        wdt_clear;
    logic        freq_change;
    logic        scs_wr_nz;
    logic        do_write;
    logic [15:0] post_mask;
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    localparam wcf_regs_t REGS_RST = '{
        st: ST_START, cfg: CFG_RST, freq_sel: FREQ_RST,
        sys_clk_sel: SRC_PRI, bresp: RESP_OKAY, rresp: RESP_OKAY,
        clk_src: SRC_PRI, default: '0};

    // =========================================================================
    // Read decode
    // =========================================================================
    always_comb begin
        rd_word = '0;
        rd_resp = RESP_OKAY;
        if (s_axi_araddr_in == OFS_WDT_CTRL) begin
            rd_word[BIT_SW_WDT_ON] = r.sw_wdt_on;
        end else if (s_axi_araddr_in == OFS_OSC_CTRL) begin
            rd_word[FREQ_MSB:FREQ_LSB] = r.freq_sel;
            rd_word[BIT_PRI_ACTIVE]    = r.pri_active;
            rd_word[SCS_MSB:SCS_LSB]   = r.sys_clk_sel;
        end else if (s_axi_araddr_in == OFS_IRQ_FLAGS2) begin
            rd_word[BIT_OSC_FAIL] = r.osc_fail_flag;
        end else if (s_axi_araddr_in == OFS_RST_CAUSE) begin
            rd_word[BIT_WDT_TO] = r.wdt_to_flag;
        end else if (s_axi_araddr_in == OFS_CONFIG) begin
            rd_word[7:0] = r.cfg;
        end else begin
            rd_resp = RESP_SLVERR;
        end
    end

    // =========================================================================
    // Next state
    // =========================================================================
    always_comb begin
        n           = r;
        n.wdt_reset = 1'b0;
        n.rc_prev   = rc_s;
        n.dev_prev  = dev_s;
        rc_rise     = rc_s & ~r.rc_prev;
        dev_fall    = ~dev_s & r.dev_prev;
        freq_change = 1'b0;
        scs_wr_nz   = 1'b0;

        // Bus write: address and data are taken in either order.
        if (s_axi_awvalid_in && r.awready) begin
            n.aw_held = 1'b1;
            n.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && r.wready) begin
            n.w_held = 1'b1;
            n.w_data = s_axi_wdata_in;
            n.w_strb = s_axi_wstrb_in;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            n.bvalid = 1'b0;
        end
        do_write = r.aw_held && r.w_held && !r.bvalid;
        if (do_write) begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            if (r.aw_addr == OFS_WDT_CTRL) begin
                if (r.w_strb[0]) begin
                    n.sw_wdt_on = r.w_data[BIT_SW_WDT_ON];
                end
            end else if (r.aw_addr == OFS_OSC_CTRL) begin
                if (r.w_strb[0]) begin
                    n.freq_sel    = r.w_data[FREQ_MSB:FREQ_LSB];
                    n.sys_clk_sel = r.w_data[SCS_MSB:SCS_LSB];
                    freq_change   = n.freq_sel != r.freq_sel;
                    scs_wr_nz     = n.sys_clk_sel != SRC_PRI;
                end
            end else if (r.aw_addr == OFS_IRQ_FLAGS2) begin
                if (r.w_strb[0] && r.w_data[BIT_OSC_FAIL]) begin
                    n.osc_fail_flag = 1'b0;
                end
            end else if (r.aw_addr == OFS_RST_CAUSE) begin
                if (r.w_strb[0] && r.w_data[BIT_WDT_TO]) begin
                    n.wdt_to_flag = 1'b0;
                end
            end else if (r.aw_addr == OFS_CONFIG) begin
                if (r.w_strb[0]) begin
                    n.cfg = r.w_data[7:0];
                end
            end else begin
                n.bresp = RESP_SLVERR;
            end
        end

        // Bus read: answered the cycle after the address is taken.
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && r.arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_word;
            n.rresp  = rd_resp;
        end

        // Fail-safe monitor. The internal source is never checked, since
        // it is the fallback and nothing could be done if it stopped.
        mon_on = r.cfg[BIT_CFG_FCM] && (r.st == ST_PRIMARY ||
                 (r.st == ST_ALT && r.sys_clk_sel == SRC_SEC));
        samp_rise = rc_rise && r.fm_div == FM_RISE_CNT;
        samp_fall = rc_rise && r.fm_div == FM_FALL_CNT;
        if (rc_rise) begin
            n.fm_div = r.fm_div + 6'h01;
        end
        if (samp_rise) begin
            n.clock_seen = 1'b0;
        end
        if (dev_fall) begin
            n.clock_seen = 1'b1;
        end
        fail_evt = mon_on && samp_fall && r.clock_seen;
        if (fail_evt) begin
            n.osc_fail_flag = 1'b1;
        end

        // Watchdog: base period in RC ticks, postscaler in base periods.
        wdt_en = r.cfg[BIT_CFG_WDT] | r.sw_wdt_on;
        wdt_clear = sleep_exec_in | clear_watchdog_in | freq_change
                  | fail_evt;
        post_mask = 16'((17'h00001 << r.cfg[PSEL_MSB:PSEL_LSB])
                  - 17'h00001);
        if (wdt_clear || !wdt_en) begin
            n.base_cnt = '0;
            n.post_cnt = '0;
        end else if (rc_rise) begin
            if (r.base_cnt == 7'(WDT_BASE_TICKS - 1)) begin
                n.base_cnt = '0;
                if (r.post_cnt == post_mask) begin
                    n.post_cnt    = '0;
                    n.wdt_reset   = 1'b1;
                    n.wdt_to_flag = 1'b1;
                end else begin
                    n.post_cnt = r.post_cnt + 16'h0001;
                end
            end else begin
                n.base_cnt = r.base_cnt + 7'h01;
            end
        end

        // Clock source sequencing.
        case (r.st)
            ST_START: begin
                if (sleep_exec_in) begin
                    n.st = ST_SLEEP;
                end else if (scs_wr_nz) begin
                    n.st = ST_ALT;
                end else if (startup_done_in) begin
                    n.st = ST_PRIMARY;
                end
            end
            ST_PRIMARY: begin
                if (sleep_exec_in) begin
                    n.st = ST_SLEEP;
                end else if (scs_wr_nz) begin
                    n.st = ST_ALT;
                end else if (fail_evt) begin
                    n.st = ST_FAIL;
                end
            end
            ST_FAIL: begin
                if (sleep_exec_in) begin
                    n.st = ST_SLEEP;
                end else if (scs_wr_nz) begin
                    n.st = ST_ALT;
                end
            end
            ST_ALT: begin
                if (sleep_exec_in) begin
                    n.st = ST_SLEEP;
                end else if (fail_evt) begin
                    n.st = ST_FAIL;
                end else if (n.sys_clk_sel == SRC_PRI && startup_done_in) begin
                    n.st = ST_PRIMARY;
                end
            end
            ST_SLEEP: begin
                if (wake_in) begin
                    n.st = (n.sys_clk_sel == SRC_PRI) ? ST_START : ST_ALT;
                end
            end
            default: begin
                n.st = ST_START;
            end
        endcase

        // The fail-safe state keeps the status bit as it was, so software
        // can tell the switch happened behind its back.
        if (n.st == ST_PRIMARY) begin
            n.pri_active = 1'b1;
        end else if (n.st != ST_FAIL) begin
            n.pri_active = 1'b0;
        end

        case (n.st)
            ST_START: begin
                n.clk_src = n.cfg[BIT_CFG_TWO_SP] ? SRC_INT : SRC_PRI;
            end
            ST_PRIMARY: begin
                n.clk_src = SRC_PRI;
            end
            ST_ALT: begin
                n.clk_src = (n.sys_clk_sel[1]) ? SRC_INT : n.sys_clk_sel;
            end
            default: begin
                n.clk_src = SRC_INT;
            end
        endcase

        n.fail_safe = n.st == ST_FAIL;
        n.rc_osc_en = n.cfg[BIT_CFG_WDT] | n.sw_wdt_on
                    | n.cfg[BIT_CFG_FCM]
                    | (n.clk_src == SRC_INT);
        n.awready = !n.aw_held && !n.bvalid;
        n.wready  = !n.w_held && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    assign s_axi_awready_out = r.awready;
    assign s_axi_wready_out  = r.wready;
    assign s_axi_bvalid_out  = r.bvalid;
    assign s_axi_bresp_out   = r.bresp;
    assign s_axi_arready_out = r.arready;
    assign s_axi_rvalid_out  = r.rvalid;
    assign s_axi_rdata_out   = r.rdata;
    assign s_axi_rresp_out   = r.rresp;
    assign wdt_reset_out     = r.wdt_reset;
    assign rc_osc_en_out     = r.rc_osc_en;
    assign clk_src_out       = r.clk_src;
    assign int_freq_sel_out  = r.freq_sel;
    assign fail_safe_out     = r.fail_safe;

    // =========================================================================
    // Assertions
    // =========================================================================
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    AST_CLEAR_ON_CMD: assert property (
        clear_watchdog_in |=> r.base_cnt == '0 && r.post_cnt == '0)
        else $error("Watchdog not cleared by clear instruction.");
    AST_TIMEOUT_CAUSE: assert property (
        wdt_reset_out |-> $past(wdt_en) && $past(rc_rise) && r.wdt_to_flag)
        else $error("Watchdog reset without an enabled timeout.");
    AST_SW_ENABLE: assert property (
        !r.cfg[BIT_CFG_WDT] && !r.sw_wdt_on |=> !wdt_reset_out)
        else $error("Watchdog fired while disabled.");
    AST_RC_KEPT_ON: assert property (
        r.cfg[BIT_CFG_FCM] |-> rc_osc_en_out)
        else $error("RC oscillator off with fail monitor enabled.");
    AST_FAIL_EFFECTS: assert property (
        fail_evt |=> fail_safe_out && clk_src_out == SRC_INT
            && r.osc_fail_flag && r.pri_active == $past(r.pri_active))
        else $error("Clock failure not handled.");
    AST_STARTUP_SWITCH: assert property (
        r.st == ST_START && startup_done_in && !sleep_exec_in && !scs_wr_nz
        |=> r.st == ST_PRIMARY && clk_src_out == SRC_PRI)
        else $error("No switch to primary after start-up timer.");
    AST_TWO_SPEED_SRC: assert property (
        r.st == ST_START && r.cfg[BIT_CFG_TWO_SP] |-> clk_src_out == SRC_INT)
        else $error("Two-speed start-up not on internal clock.");
    AST_ALT_IGNORES: assert property (
        r.st == ST_ALT && r.sys_clk_sel == SRC_PRI |-> clk_src_out == SRC_PRI)
        else $error("Two-speed used in another power mode.");
    AST_MON_SOURCES: assert property (
        fail_evt |-> r.st == ST_PRIMARY || r.st == ST_ALT)
        else $error("Monitor acted on the internal source.");
    AST_SEEN_SET: assert property (
        dev_fall |=> r.clock_seen)
        else $error("Clock-seen latch not set by device clock.");
    AST_PRI_STATUS: assert property (
        r.st == ST_PRIMARY |-> r.pri_active
            ##1 (r.st != ST_PRIMARY || r.pri_active))
        else $error("Primary-active bit clear while primary runs.");

    COV_TIMEOUT: cover property (wdt_reset_out);
    COV_FAIL: cover property (fail_evt ##1 fail_safe_out);
    COV_STARTUP: cover property (r.st == ST_START ##1 r.st == ST_PRIMARY);
    COV_WRITE: cover property (s_axi_bvalid_out && s_axi_bready_in);

endmodule // wcf_top

/* common/wcf_pkg.sv */
// Constants, register map and state types of the watchdog and clock fail-safe.
package wcf_pkg;

    // =========================================================================
    // Bus and register map
    // =========================================================================
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam logic [7:0]  OFS_WDT_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_OSC_CTRL   = 8'h04;
    localparam logic [7:0]  OFS_IRQ_FLAGS2 = 8'h08;
    localparam logic [7:0]  OFS_RST_CAUSE  = 8'h0C;
    localparam logic [7:0]  OFS_CONFIG     = 8'h10;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // =========================================================================
    // Field positions
    // =========================================================================
    localparam int          BIT_SW_WDT_ON  = 0;
    localparam int          FREQ_LSB       = 4;
    localparam int          FREQ_MSB       = 6;
    localparam int          BIT_PRI_ACTIVE = 3;
    localparam int          SCS_LSB        = 0;
    localparam int          SCS_MSB        = 1;
    localparam int          BIT_OSC_FAIL   = 7;
    localparam int          BIT_WDT_TO     = 3;
    localparam int          BIT_CFG_WDT    = 0;
    localparam int          BIT_CFG_TWO_SP = 1;
    localparam int          BIT_CFG_FCM    = 2;
    localparam int          PSEL_LSB       = 4;
    localparam int          PSEL_MSB       = 7;

    // =========================================================================
    // Reset values
    // =========================================================================
    localparam logic [7:0]  CFG_RST        = 8'hF0;
    localparam logic [2:0]  FREQ_RST       = 3'h0;

    // =========================================================================
    // Clock sources and timing
    // =========================================================================
    localparam logic [1:0]  SRC_PRI        = 2'h0;
    localparam logic [1:0]  SRC_SEC        = 2'h1;
    localparam logic [1:0]  SRC_INT        = 2'h2;
    localparam int          WDT_BASE_US    = 4000;
    localparam int          RC_FREQ_HZ     = 31250;
    localparam int          WDT_BASE_TICKS = WDT_BASE_US * RC_FREQ_HZ / 1000000;
    localparam int          FM_DIV         = 64;
    localparam logic [5:0]  FM_RISE_CNT    = 6'(FM_DIV / 2 - 1);
    localparam logic [5:0]  FM_FALL_CNT    = 6'(FM_DIV - 1);

    typedef enum logic [2:0] {
        ST_START   = 3'b000,
        ST_PRIMARY = 3'b001,
        ST_FAIL    = 3'b010,
        ST_ALT     = 3'b011,
        ST_SLEEP   = 3'b100
    } wcf_state_t;

    typedef struct packed {
        logic meta;
        logic stable;
    } wcf_sync_t;

    typedef struct packed {
        wcf_state_t  st;
        logic        sw_wdt_on;
        logic [2:0]  freq_sel;
        logic [1:0]  sys_clk_sel;
        logic        pri_active;
        logic        osc_fail_flag;
        logic        wdt_to_flag;
        logic [7:0]  cfg;
        logic        rc_prev;
        logic        dev_prev;
        logic [6:0]  base_cnt;
        logic [15:0] post_cnt;
        logic [5:0]  fm_div;
        logic        clock_seen;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        wdt_reset;
        logic        rc_osc_en;
        logic [1:0]  clk_src;
        logic        fail_safe;
    } wcf_regs_t;

endpackage

/* core/wcf_sync.sv */
// Two-stage synchroniser with a constant reset value.
`timescale 1ns/10ps
module wcf_sync
    import wcf_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic d_in,
    output logic      q_out
);
    import wcf_pkg::*;

    wcf_sync_t r;
    wcf_sync_t n;

    always_comb begin
        n.meta   = d_in;
        n.stable = r.meta;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '{meta: RST_VAL, stable: RST_VAL};
        end else begin
            r <= n;
        end
    end

    assign q_out = r.stable;

endmodule // wcf_sync

/* sim/tb_top.sv */
// Self-checking bench of the watchdog and clock fail-safe block.
`timescale 1ns/10ps
module tb_top;
    import wcf_pkg::*;
    // ==============================================
    // Signals and design
    // ==============================================
    logic        mclk_in, rst_n_in, run;
    logic        rc_clk_in = 1'b0;
    logic        dev_clk_in = 1'b0;
    logic        sleep_exec_in, clear_watchdog_in, wake_in, startup_done_in;
    logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    logic        s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out;
    logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic        s_axi_rvalid_out, wdt_reset_out, rc_osc_en_out;
    logic        fail_safe_out;
    logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
    logic [3:0]  s_axi_wstrb_in;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, clk_src_out, r;
    logic [1:0]  c = 2'h0;
    logic [2:0]  int_freq_sel_out, f;
    int          err_count, n_checks, seed, n, i;
    wcf_top u_dut (.*);
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    // A fast RC clock keeps the timeouts tested (postscaler settings 0 and 2) within a short run.
    always @(posedge mclk_in) begin
        c          <= c + 2'h1;
        rc_clk_in  <= c[1];
        dev_clk_in <= dev_clk_in ^ run;
    end
    task automatic wrap_up;
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a);
        logic ha, hw, ok;
        ok = 1'b0;
        @(posedge mclk_in);
        s_axi_awaddr_in <= a;
        s_axi_araddr_in <= a;
        s_axi_wdata_in  <= {24'($random(seed)), d[7:0]};
        if (w) {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        else {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        for (int k = 0; k < 99 && !ok; k++) begin
            #1;
            ha = w ? s_axi_awvalid_in & s_axi_awready_out
                   : s_axi_arvalid_in & s_axi_arready_out;
            hw = s_axi_wvalid_in & s_axi_wready_out;
            ok = w ? s_axi_bready_in & s_axi_bvalid_out
                   : s_axi_rready_in & s_axi_rvalid_out;
            r = w ? s_axi_bresp_out : s_axi_rresp_out;
            if (!w) d = s_axi_rdata_out;
            @(posedge mclk_in);
            if (ha && w) s_axi_awvalid_in <= 1'b0;
            if (ha && !w) s_axi_arvalid_in <= 1'b0;
            if (hw) s_axi_wvalid_in <= 1'b0;
            if (ok) {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
        end
        if (!ok) begin
            err_count++;
            wrap_up;
        end
    endtask
    // Event bits: 3 sleep, 2 clear, 1 wake, 0 start-up timer done.
    task automatic pulse(input int k);
        @(posedge mclk_in);
        {sleep_exec_in, clear_watchdog_in, wake_in, startup_done_in} <=
            4'(1 << k);
        @(posedge mclk_in);
        {sleep_exec_in, clear_watchdog_in, wake_in, startup_done_in} <= 4'h0;
        repeat (3) @(posedge mclk_in);
        #1;
    endtask
    task automatic wait_ev(input logic fs, input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge mclk_in);
            #1;
            if ((fs ? fail_safe_out : wdt_reset_out) === 1'b1) break;
        end
    endtask
    function automatic logic in_win(input int g, input int sel);
        int e;
        e = WDT_BASE_TICKS * 4 << sel;
        return g > e - 24 && g < e + 24;
    endfunction
    initial begin
        seed = 34;
        {err_count, n_checks, run, rst_n_in, f, d} = '0;
        {sleep_exec_in, clear_watchdog_in, wake_in, startup_done_in} = 4'h0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
        s_axi_wstrb_in = 4'hF;
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        xfer(0, OFS_WDT_CTRL);
        chk(d, 0);
        xfer(0, 8'h40);
        chk(r, RESP_SLVERR);
        d = 32'hFF;
        xfer(1, OFS_WDT_CTRL);
        chk(r, RESP_OKAY);
        xfer(0, OFS_WDT_CTRL);
        chk(d, 1);
        chk(rc_osc_en_out, 1);
        for (i = 2; i >= 0; i -= 2) begin
            d = 32'(i << PSEL_LSB);
            xfer(1, OFS_CONFIG);
            pulse(2);
            wait_ev(0, 3000);
            chk(in_win(n, i), 1);
        end
        xfer(0, OFS_RST_CAUSE);
        chk(d[BIT_WDT_TO], 1);
        for (i = 0; i < 2; i++) begin
            repeat (300) @(posedge mclk_in);
            f = 3'(1 + {$random(seed)} % 7);
            d = {25'h0, f, 4'h0};
            if (i == 0) pulse(2);
            else xfer(1, OFS_OSC_CTRL);
            wait_ev(0, 3000);
            chk(in_win(n, 0), 1);
        end
        chk(int_freq_sel_out, f);
        d = 32'h0;
        xfer(1, OFS_WDT_CTRL);
        wait_ev(0, 1500);
        chk(n, 1500);
        d = 32'h1 << BIT_CFG_WDT;
        xfer(1, OFS_CONFIG);
        pulse(2);
        wait_ev(0, 3000);
        chk(in_win(n, 0), 1);
        d = 32'h1 << BIT_CFG_FCM;
        xfer(1, OFS_CONFIG);
        pulse(0);
        chk(rc_osc_en_out, 1);
        chk(clk_src_out, SRC_PRI);
        wait_ev(1, 800);
        chk(n, 800);
        run <= 1'b1;
        wait_ev(1, 800);
        chk(n < 600, 1);
        chk(clk_src_out, SRC_INT);
        xfer(0, OFS_OSC_CTRL);
        chk(d, {25'h0, f, 4'h8});
        xfer(0, OFS_IRQ_FLAGS2);
        chk(d[BIT_OSC_FAIL], 1);
        run <= 1'b0;
        d = 32'h80;
        xfer(1, OFS_IRQ_FLAGS2);
        xfer(0, OFS_IRQ_FLAGS2);
        chk(d, 0);
        pulse(3);
        chk(fail_safe_out, 0);
        for (i = 0; i < 2; i++) begin
            d = 32'(i << BIT_CFG_TWO_SP);
            xfer(1, OFS_CONFIG);
            pulse(3);
            pulse(1);
            chk(clk_src_out, i ? SRC_INT : SRC_PRI);
            chk(int_freq_sel_out, f);
            pulse(0);
            chk(clk_src_out, SRC_PRI);
        end
        wrap_up;
    end
endmodule // tb_top
